// ---- uart_line_modem_status.sv ----
/*
 * Line status, modem status, modem control, loop-back and scratch logic
 * of one serial channel, with its register port.
 * Assumes a receiver core that reports each finished character as a
 * one-cycle pulse with its bits, a transmitter core that reports its
 * holding and shift register state, and a bit-time tick on i_clock.
 */
// Added by the designer: strobed register access and the address map.
// Summary of operation
// R1 - Control bit 4 selects local loop-back
// R2 - Data ready while receive holding register full
// R3 - Overrun flagged; held character kept intact
// R4 - Parity error on parity mismatch
// R5 - Framing error on missing stop bit
// R6 - Break after receive low one frame
// R7 - Holding empty flag; interrupt when enabled
// R8 - Transmitter empty when both registers empty
// R9 - Change flags set on modem input change
// R10 - Reading modem status clears change flags
// R11 - Ring change only on trailing edge
// R12 - Any change flag requests modem interrupt
// R13 - Upper status bits invert modem pins
// R14 - Loop-back maps control bits onto status
// R15 - Scratch register stores and returns data
// R16 - Control bits 0/1 drive ready/request outputs
// R17 - Modem interrupt gated by enable bit
// R18 - Reading line status clears error flags
// R19 - Loop-back idles outputs, routes data internally
`timescale 1ns/100ps
module uart_line_modem_status (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire uart_lms_pkg::reg_req_s i_req,
    output logic [7:0] o_rdata,
    input wire uart_lms_pkg::modem_pins_s i_modem_n,
    input wire logic i_rx_pin,
    input wire logic i_tx_serial,
    input wire logic i_bit_tick,
    input wire uart_lms_pkg::rx_char_s i_rx_char,
    input wire uart_lms_pkg::line_cfg_s i_cfg,
    input wire logic i_thr_empty,
    input wire logic i_tsr_empty,
    output logic o_rx_serial,
    output logic o_tx_pin,
    output logic o_dtr_n,
    output logic o_rts_n,
    output logic o_modem_int,
    output logic o_tx_int
);
    import uart_lms_pkg::*;

    state_s st_q;
    state_s st_d;
    logic loop;
    logic rhr_rd;
    logic lsr_rd;
    logic msr_rd;
    logic [3:0] status;
    logic [3:0] chg;
    logic exp_par;
    logic pe_set;
    logic fe_set;
    logic oe_set;
    logic bi_set;
    logic rx_load;
    logic [3:0] fbits;

    function automatic logic [7:0] data_mask(input logic [1:0] wl);
        unique case (wl)
            2'h0: data_mask = 8'h1f;
            2'h1: data_mask = 8'h3f;
            2'h2: data_mask = 8'h7f;
            default: data_mask = 8'hff;
        endcase
    endfunction

    // Half stop bit rounded up: break needs the line low a touch longer
    function automatic logic [3:0] frame_bits(input line_cfg_s c);
        frame_bits = 4'h6 + {2'h0, c.word_len} + {3'h0, c.parity_en} + (c.two_stop ? 4'h2 : 4'h1);
    endfunction

    always_comb begin
        st_d = st_q;
        loop = st_q.modem_control[MC_LOOP];
        rhr_rd = i_req.rd && (i_req.addr == OFS_RX_HOLD);
        lsr_rd = i_req.rd && (i_req.addr == OFS_LINE_STAT);
        msr_rd = i_req.rd && (i_req.addr == OFS_MODEM_STAT);
        if (loop) begin // R14
            status = {st_q.modem_control[MC_OUT2], st_q.modem_control[MC_OUT1], st_q.modem_control[MC_DTR], st_q.modem_control[MC_RTS]};
        end else begin
            status = ~st_q.mstable; // R13
        end
        chg = status ^ st_q.prev; // R9
        chg[ML_RI] = st_q.prev[ML_RI] & ~status[ML_RI]; // R11
        exp_par = i_cfg.parity_force ? ~i_cfg.parity_even
            : (i_cfg.parity_even ? ^(i_rx_char.data & data_mask(i_cfg.word_len))
            : ~^(i_rx_char.data & data_mask(i_cfg.word_len)));
        pe_set = i_rx_char.done && i_cfg.parity_en && (i_rx_char.parity_bit != exp_par); // R4
        fe_set = i_rx_char.done && !i_rx_char.stop_ok; // R5
        oe_set = i_rx_char.done && st_q.dr && !rhr_rd; // R3
        rx_load = i_rx_char.done && !oe_set;
        fbits = frame_bits(i_cfg);
        bi_set = i_bit_tick && !st_q.rxd && (st_q.brk_cnt != fbits) && ((st_q.brk_cnt + 4'h1) == fbits); // R6
        if (i_clk_en) begin
            // Three-stage pin sync; a level counts once stages 2 and 3 agree
            st_d.m1 = i_modem_n;
            st_d.m2 = st_q.m1;
            st_d.m3 = st_q.m2;
            st_d.mstable = (~(st_q.m2 ^ st_q.m3) & st_q.m3) | ((st_q.m2 ^ st_q.m3) & st_q.mstable);
            st_d.rx1 = i_rx_pin;
            st_d.rx2 = st_q.rx1;
            st_d.rx3 = st_q.rx2;
            if (st_q.rx2 == st_q.rx3) begin
                st_d.rx_stable = st_q.rx3;
            end
            st_d.prev = status;
            // Set wins over the read clear so no change is lost
            st_d.delta = (msr_rd ? 4'h0 : st_q.delta) | chg; // R9 R10
            if (i_bit_tick) begin
                if (st_q.rxd) begin
                    st_d.brk_cnt = 4'h0;
                end else if (st_q.brk_cnt != fbits) begin
                    st_d.brk_cnt = st_q.brk_cnt + 4'h1;
                end
            end
            if (rx_load) begin // R2
                st_d.receive_holding_reg = i_rx_char.data;
                st_d.dr = 1'h1;
            end else if (rhr_rd) begin
                st_d.dr = 1'h0;
            end
            st_d.oe = (st_q.oe && !lsr_rd) || oe_set; // R18
            st_d.pe = (st_q.pe && !lsr_rd) || pe_set; // R18
            st_d.fe = (st_q.fe && !lsr_rd) || fe_set; // R18
            st_d.bi = (st_q.bi && !lsr_rd) || bi_set; // R18
            st_d.thre = i_thr_empty; // R7
            st_d.temt = i_thr_empty && i_tsr_empty; // R8
            if (i_req.wr) begin
                unique case (i_req.addr)
                    OFS_INT_EN: st_d.interrupt_enable = i_req.wdata[3:0];
                    OFS_MODEM_CTRL: st_d.modem_control = i_req.wdata[4:0]; // R1
                    OFS_SCRATCH: st_d.scratch = i_req.wdata; // R15
                    default: ;
                endcase
            end
            st_d.rdata = 8'h00;
            if (i_req.rd) begin
                unique case (i_req.addr)
                    OFS_RX_HOLD: st_d.rdata = st_q.receive_holding_reg;
                    OFS_INT_EN: st_d.rdata = {4'h0, st_q.interrupt_enable};
                    OFS_MODEM_CTRL: st_d.rdata = {3'h0, st_q.modem_control};
                    OFS_LINE_STAT: st_d.rdata = {1'h0, st_q.temt, st_q.thre, st_q.bi, st_q.fe, st_q.pe,
                        st_q.oe, st_q.dr};
                    OFS_MODEM_STAT: st_d.rdata = {status, st_q.delta};
                    OFS_SCRATCH: st_d.rdata = st_q.scratch; // R15
                    default: st_d.rdata = 8'h00;
                endcase
            end
            // Outputs follow the new control value to save a cycle
            st_d.dtr_n = !(st_d.modem_control[MC_DTR] && !st_d.modem_control[MC_LOOP]); // R16 R19
            st_d.rts_n = !(st_d.modem_control[MC_RTS] && !st_d.modem_control[MC_LOOP]); // R16 R19
            st_d.txd = st_d.modem_control[MC_LOOP] ? 1'h1 : i_tx_serial; // R19
            st_d.rxd = st_d.modem_control[MC_LOOP] ? i_tx_serial : st_q.rx_stable; // R1 R19
            st_d.mint = (|st_d.delta) && st_d.interrupt_enable[IE_MODEM]; // R12 R17
            st_d.tint = st_d.thre && st_d.interrupt_enable[IE_TX]; // R7
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_rx_serial = st_q.rxd;
    assign o_tx_pin = st_q.txd;
    assign o_dtr_n = st_q.dtr_n;
    assign o_rts_n = st_q.rts_n;
    assign o_modem_int = st_q.mint;
    assign o_tx_int = st_q.tint;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    sequence scr_write;
        i_clk_en && i_req.wr && (i_req.addr == OFS_SCRATCH);
    endsequence

    sequence scr_read;
        i_clk_en && i_req.rd && !i_req.wr && (i_req.addr == OFS_SCRATCH);
    endsequence

    sequence msr_read_loop;
        i_clk_en && msr_rd && loop;
    endsequence

    AST_LOOP_IDLE: assert property (st_q.modem_control[MC_LOOP] |-> o_tx_pin && o_dtr_n && o_rts_n) // R19
        else $error("loop-back outputs not idle");
    AST_LOOP_ROUTE: assert property (i_clk_en && st_q.modem_control[MC_LOOP] && !i_req.wr // R1
        |=> o_rx_serial == $past(i_tx_serial))
        else $error("loop-back data not routed");
    AST_CTRL_OUT: assert property (!st_q.modem_control[MC_LOOP] // R16
        |-> o_dtr_n == !st_q.modem_control[MC_DTR] && o_rts_n == !st_q.modem_control[MC_RTS])
        else $error("modem control outputs wrong");
    AST_DATA_READY: assert property (i_clk_en && i_rx_char.done && !st_q.dr // R2
        |=> st_q.dr && st_q.receive_holding_reg == $past(i_rx_char.data))
        else $error("received character not held");
    AST_DR_CLEAR: assert property (i_clk_en && rhr_rd && !i_rx_char.done |=> !st_q.dr) // R2
        else $error("data ready not cleared by read");
    AST_PARITY: assert property (i_clk_en && pe_set |=> st_q.pe) // R4
        else $error("parity error not flagged");
    AST_BREAK: assert property (i_clk_en && bi_set |=> st_q.bi) // R6
        else $error("break not flagged");
    AST_OVERRUN: assert property (i_clk_en && oe_set |=> st_q.oe && st_q.dr && st_q.receive_holding_reg == $past(st_q.receive_holding_reg)) // R3
        else $error("overrun handling wrong");
    AST_FRAMING: assert property (i_clk_en && fe_set |=> st_q.fe) // R5
        else $error("framing error not flagged");
    AST_TX_EMPTY: assert property (i_clk_en |=> st_q.temt == ($past(i_thr_empty) && $past(i_tsr_empty))) // R8
        else $error("transmitter empty flag wrong");
    AST_TX_INT: assert property (st_q.thre && st_q.interrupt_enable[IE_TX] |-> o_tx_int) // R7
        else $error("holding empty interrupt missing");
    AST_MSR_CLEAR: assert property (i_clk_en && msr_rd && chg == 4'h0 |=> st_q.delta == 4'h0) // R10
        else $error("change flags not cleared by read");
    AST_RI_LEAD: assert property (i_clk_en && !msr_rd && !st_q.prev[ML_RI] && status[ML_RI] // R11
        |=> st_q.delta[ML_RI] == $past(st_q.delta[ML_RI]))
        else $error("ring change set on leading edge");
    AST_RI_TRAIL: assert property (i_clk_en && st_q.prev[ML_RI] && !status[ML_RI] |=> st_q.delta[ML_RI]) // R11
        else $error("ring trailing edge not flagged");
    AST_MSR_SET: assert property (i_clk_en && (chg != 4'h0) |=> (st_q.delta & $past(chg)) == $past(chg)) // R9
        else $error("change flag not set");
    AST_MODEM_INT: assert property (o_modem_int == ((|st_q.delta) && st_q.interrupt_enable[IE_MODEM])) // R12
        else $error("modem interrupt mismatch");
    AST_MODEM_MASK: assert property (!st_q.interrupt_enable[IE_MODEM] |-> !o_modem_int) // R17
        else $error("modem interrupt leaked while disabled");
    AST_MSR_PINS: assert property (i_clk_en && msr_rd && !loop |=> o_rdata[7:4] == ~$past(st_q.mstable)) // R13
        else $error("status bits do not mirror pins");
    AST_MSR_LOOP: assert property (msr_read_loop |=> o_rdata[7:4] == {$past(st_q.modem_control[MC_OUT2]), // R14
        $past(st_q.modem_control[MC_OUT1]), $past(st_q.modem_control[MC_DTR]), $past(st_q.modem_control[MC_RTS])})
        else $error("loop-back status mapping wrong");
    AST_SCRATCH: assert property (scr_write ##1 scr_read |=> o_rdata == $past(i_req.wdata, 2)) // R15
        else $error("scratch value not returned");
    AST_LSR_CLEAR: assert property (i_clk_en && lsr_rd && !oe_set && !pe_set |=> !st_q.oe && !st_q.pe) // R18
        else $error("error flags not cleared by read");

endmodule

// ---- uart_lms_pkg.sv ----
/*
 * Package for the line and modem status block of one serial channel:
 * register offsets, bit positions, reset values and the carrier structs.
 * Assumes one 250 MHz clock domain and an 8-bit register port.
 */
package uart_lms_pkg;

    // Register offsets on the 3-bit register port
    localparam logic [2:0] OFS_RX_HOLD = 3'h0;
    localparam logic [2:0] OFS_INT_EN = 3'h1;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT = 3'h5;
    localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;

    // modem_control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;

    // interrupt_enable fields
    localparam int IE_TX = 1;
    localparam int IE_MODEM = 3;

    // Modem line index inside the 4-bit groups (change flags and status)
    localparam int ML_CTS = 0;
    localparam int ML_DSR = 1;
    localparam int ML_RI = 2;
    localparam int ML_CD = 3;

    // Reset values
    localparam logic [4:0] MCR_RST = 5'h00;
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [3:0] PINS_IDLE = 4'hf;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Active-low modem inputs; bit order matches the ML_* indices
    typedef struct packed {
        logic carrier_detect_n;
        logic ring_indicator_n;
        logic dsr_n;
        logic cts_n;
    } modem_pins_s;

    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic parity_bit;
        logic stop_ok;
    } rx_char_s;

    typedef struct packed {
        logic [1:0] word_len;
        logic two_stop;
        logic parity_en;
        logic parity_even;
        logic parity_force;
    } line_cfg_s;

    typedef struct packed {
        logic [3:0] m1;
        logic [3:0] m2;
        logic [3:0] m3;
        logic [3:0] mstable;
        logic [3:0] prev;
        logic [3:0] delta;
        logic rx1;
        logic rx2;
        logic rx3;
        logic rx_stable;
        logic [4:0] modem_control;
        logic [3:0] interrupt_enable;
        logic [7:0] scratch;
        logic [7:0] receive_holding_reg;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic [3:0] brk_cnt;
        logic thre;
        logic temt;
        logic [7:0] rdata;
        logic dtr_n;
        logic rts_n;
        logic txd;
        logic rxd;
        logic mint;
        logic tint;
    } state_s;

    localparam state_s STATE_RST = '{m1: PINS_IDLE, m2: PINS_IDLE, m3: PINS_IDLE, mstable: PINS_IDLE,
        rx1: 1'h1, rx2: 1'h1, rx3: 1'h1, rx_stable: 1'h1, modem_control: MCR_RST, interrupt_enable: IER_RST,
        scratch: DATA_RST, receive_holding_reg: DATA_RST, thre: 1'h1, temt: 1'h1, rdata: DATA_RST,
        dtr_n: 1'h1, rts_n: 1'h1, txd: 1'h1, rxd: 1'h1, default: '0};

endpackage

// ---- uart_modem_model.sv ----
/* Modem side model: handshake pins and serial receive line.
   Assumes the bench sets the wanted levels; all pins idle high. */
`timescale 1ns/100ps
module uart_modem_model
    import uart_lms_pkg::*;
(
    input wire logic i_clock,
    input wire uart_lms_pkg::modem_pins_s i_want,
    input wire logic i_want_rx,
    output uart_lms_pkg::modem_pins_s o_modem_n,
    output logic o_rx_pin
);
    // Pins are asynchronous to the device, so any edge offset is legal
    always @(posedge i_clock) begin
        o_modem_n <= i_want;
        o_rx_pin <= i_want_rx;
    end
endmodule

// ---- uart_line_modem_status_tb_top.sv ----
/* Self-checking bench for the line and modem status block.
   Assumes the design package and the modem model are compiled first. */
`timescale 1ns/100ps
module uart_line_modem_status_tb_top;
    import uart_lms_pkg::*;
    logic i_clock;
    logic i_rst_b;
    reg_req_s req;
    logic [7:0] rdata;
    modem_pins_s want;
    modem_pins_s pins;
    rx_char_s rx_char;
    line_cfg_s cfg;
    logic want_rx, rx_pin, tx_serial, bit_tick, thr_empty, tsr_empty, clk_en;
    logic rx_serial, tx_pin, dtr_n, rts_n, modem_int, tx_int;
    int fails, n_checks, cycles;

    uart_modem_model modem (.i_clock(i_clock), .i_want(want), .i_want_rx(want_rx), .o_modem_n(pins),
        .o_rx_pin(rx_pin));
    uart_line_modem_status uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(clk_en), .i_req(req),
        .o_rdata(rdata), .i_modem_n(pins), .i_rx_pin(rx_pin), .i_tx_serial(tx_serial), .i_bit_tick(bit_tick),
        .i_rx_char(rx_char), .i_cfg(cfg), .i_thr_empty(thr_empty), .i_tsr_empty(tsr_empty),
        .o_rx_serial(rx_serial), .o_tx_pin(tx_pin), .o_dtr_n(dtr_n), .o_rts_n(rts_n),
        .o_modem_int(modem_int), .o_tx_int(tx_int));

    initial begin
        i_clock = 1'h0;
        forever #2 i_clock = ~i_clock;
    end

    // Whole run needs about 270 cycles; generous ceiling
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'h1;
        @(posedge i_clock);
        req.wr <= 1'h0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clock);
        req.addr <= a;
        req.rd <= 1'h1;
        @(posedge i_clock);
        req.rd <= 1'h0;
        #1;
        chk(name, exp, rdata);
        @(posedge i_clock);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge i_clock);
            bit_tick <= 1'h1;
            @(posedge i_clock);
            bit_tick <= 1'h0;
        end
    endtask

    task automatic rx(input logic [7:0] d, input logic par, input logic stop_ok);
        @(posedge i_clock);
        rx_char <= '{done: 1'h1, data: d, parity_bit: par, stop_ok: stop_ok};
        @(posedge i_clock);
        rx_char.done <= 1'h0;
        cyc(2);
    endtask

    task automatic t_reset();
        cyc(8);
        chk("dtr_n", 8'h01, {7'h0, dtr_n});
        chk("tx_pin", 8'h01, {7'h0, tx_pin});
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        rd(OFS_MODEM_STAT, 8'h00, "modem_status");
        $display("test reset done");
    endtask

    task automatic t_scratch();
        wr(OFS_SCRATCH, 8'ha5);
        rd(OFS_SCRATCH, 8'ha5, "scratch");
        wr(OFS_SCRATCH, 8'h5a);
        rd(3'h2, 8'h00, "unmapped");
        rd(OFS_SCRATCH, 8'h5a, "scratch");
        // Write then read with no gap between the strobes
        @(posedge i_clock);
        req.addr <= OFS_SCRATCH;
        req.wdata <= 8'h3c;
        req.wr <= 1'h1;
        @(posedge i_clock);
        req.wr <= 1'h0;
        req.rd <= 1'h1;
        @(posedge i_clock);
        req.rd <= 1'h0;
        #1;
        chk("scratch", 8'h3c, rdata);
        // A write while the clock enable is low must be ignored
        @(posedge i_clock);
        clk_en <= 1'h0;
        wr(OFS_SCRATCH, 8'hff);
        clk_en <= 1'h1;
        rd(OFS_SCRATCH, 8'h3c, "scratch");
        $display("test scratch done");
    endtask

    task automatic t_control();
        wr(OFS_MODEM_CTRL, 8'h03);
        cyc(1);
        chk("dtr_rts", 8'h00, {6'h0, dtr_n, rts_n});
        wr(OFS_MODEM_CTRL, 8'h01);
        cyc(1);
        chk("dtr_rts", 8'h01, {6'h0, dtr_n, rts_n});
        rd(OFS_MODEM_CTRL, 8'h01, "modem_control");
        wr(OFS_MODEM_CTRL, 8'h00);
        $display("test control done");
    endtask

    task automatic t_modem();
        wr(OFS_INT_EN, 8'h08);
        want.cts_n <= 1'h0;
        cyc(8);
        chk("modem_int", 8'h01, {7'h0, modem_int});
        rd(OFS_MODEM_STAT, 8'h11, "modem_status");
        cyc(2);
        chk("modem_int", 8'h00, {7'h0, modem_int});
        rd(OFS_MODEM_STAT, 8'h10, "modem_status");
        want.ring_indicator_n <= 1'h0;
        cyc(8);
        rd(OFS_MODEM_STAT, 8'h50, "modem_status");
        want.ring_indicator_n <= 1'h1;
        cyc(8);
        rd(OFS_MODEM_STAT, 8'h14, "modem_status");
        wr(OFS_INT_EN, 8'h00);
        want.cts_n <= 1'h1;
        cyc(8);
        chk("modem_int", 8'h00, {7'h0, modem_int});
        rd(OFS_MODEM_STAT, 8'h01, "modem_status");
        $display("test modem done");
    endtask

    task automatic t_loop();
        tx_serial <= 1'h0;
        cyc(2);
        chk("tx_pin", 8'h00, {7'h0, tx_pin});
        wr(OFS_MODEM_CTRL, 8'h1a);
        cyc(8);
        rd(OFS_MODEM_STAT, 8'h99, "modem_status");
        chk("loop_pins", 8'h07, {5'h0, dtr_n, rts_n, tx_pin});
        chk("rx_serial", 8'h00, {7'h0, rx_serial});
        wr(OFS_MODEM_CTRL, 8'h15);
        cyc(8);
        // Ring goes active here, a leading edge, so its flag stays clear
        rd(OFS_MODEM_STAT, 8'h6b, "modem_status");
        chk("loop_pins", 8'h07, {5'h0, dtr_n, rts_n, tx_pin});
        wr(OFS_MODEM_CTRL, 8'h00);
        tx_serial <= 1'h1;
        cyc(8);
        rd(OFS_MODEM_STAT, 8'h06, "modem_status");
        $display("test loop done");
    endtask

    task automatic t_receive();
        cfg <= '{word_len: 2'h3, two_stop: 1'h0, parity_en: 1'h1, parity_even: 1'h1, parity_force: 1'h0};
        rx(8'h3c, 1'h0, 1'h1);
        rd(OFS_LINE_STAT, 8'h61, "line_status");
        rx(8'h01, 1'h0, 1'h0);
        rd(OFS_LINE_STAT, 8'h6f, "line_status");
        rd(OFS_RX_HOLD, 8'h3c, "receive_holding_reg");
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        // Five bit odd parity: bits above the word must not count
        cfg <= '{word_len: 2'h0, two_stop: 1'h0, parity_en: 1'h1, parity_even: 1'h0, parity_force: 1'h0};
        rx(8'he1, 1'h0, 1'h1);
        rd(OFS_LINE_STAT, 8'h61, "line_status");
        rd(OFS_RX_HOLD, 8'he1, "receive_holding_reg");
        cfg <= '{word_len: 2'h0, two_stop: 1'h0, parity_en: 1'h1, parity_even: 1'h1, parity_force: 1'h1};
        rx(8'h00, 1'h1, 1'h1);
        rd(OFS_LINE_STAT, 8'h65, "line_status");
        rd(OFS_RX_HOLD, 8'h00, "receive_holding_reg");
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        $display("test receive done");
    endtask

    task automatic t_break();
        cfg <= '0;
        want_rx <= 1'h0;
        cyc(8);
        chk("rx_serial", 8'h00, {7'h0, rx_serial});
        // Five data bits and one stop bit make a seven bit frame
        ticks(6);
        cyc(2);
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        ticks(2);
        cyc(2);
        rd(OFS_LINE_STAT, 8'h70, "line_status");
        want_rx <= 1'h1;
        cyc(8);
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        $display("test break done");
    endtask

    task automatic t_transmit();
        wr(OFS_INT_EN, 8'h02);
        thr_empty <= 1'h0;
        tsr_empty <= 1'h0;
        cyc(3);
        chk("tx_int", 8'h00, {7'h0, tx_int});
        rd(OFS_LINE_STAT, 8'h00, "line_status");
        thr_empty <= 1'h1;
        cyc(3);
        chk("tx_int", 8'h01, {7'h0, tx_int});
        rd(OFS_LINE_STAT, 8'h20, "line_status");
        tsr_empty <= 1'h1;
        cyc(3);
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        $display("test transmit done");
    endtask

    task automatic t_mid_reset();
        wr(OFS_MODEM_CTRL, 8'h03);
        wr(OFS_SCRATCH, 8'h77);
        i_rst_b <= 1'h0;
        cyc(2);
        // First request rides on the first edge with reset released
        i_rst_b <= 1'h1;
        req.addr <= OFS_MODEM_CTRL;
        req.rd <= 1'h1;
        @(posedge i_clock);
        req.rd <= 1'h0;
        #1;
        chk("modem_control", 8'h00, rdata);
        chk("dtr_rts", 8'h03, {6'h0, dtr_n, rts_n});
        chk("tx_int", 8'h00, {7'h0, tx_int});
        rd(OFS_SCRATCH, DATA_RST, "scratch");
        rd(OFS_LINE_STAT, 8'h60, "line_status");
        $display("test mid reset done");
    endtask

    initial begin
        i_rst_b = 1'h0;
        req = '0;
        want = PINS_IDLE;
        want_rx = 1'h1;
        tx_serial = 1'h1;
        bit_tick = 1'h0;
        rx_char = '0;
        cfg = '0;
        thr_empty = 1'h1;
        tsr_empty = 1'h1;
        clk_en = 1'h1;
        fails = 0;
        n_checks = 0;
        cycles = 0;
        repeat (6) @(posedge i_clock);
        i_rst_b <= 1'h1;
        t_reset();
        t_scratch();
        t_control();
        t_modem();
        t_loop();
        t_receive();
        t_break();
        t_transmit();
        t_mid_reset();
        end_sim();
    end
endmodule
